// [core/pfc_host.sv]
// Notes on behaviour
// - Host issues each command by lowering write strobe with chip select low.
// - Sector erase: write 20h anywhere, then d0h inside sector; bits 18..8 pick it.
// - Program: write 10h anywhere, then data at the full target address.
// - Lock is toggled only by seven consecutive reads at fixed addresses.
// - Host runs the seven-read unlock before every program or erase.
// - Writing ffh after a setup byte cancels it and returns to read mode.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_consts.svh"
module pfc_host #(
  parameter logic [`PFC_WAIT_W-1:0] PROG_WAIT_CYC  = `PFC_WAIT_W'(`PFC_PROG_CYC),
  parameter logic [`PFC_WAIT_W-1:0] ERASE_WAIT_CYC = `PFC_WAIT_W'(`PFC_ERASE_CYC)
) (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire pfc_pkg::pfc_op_e       cmd_op,
  input  wire logic [`PFC_ADDR_W-1:0] cmd_addr,
  input  wire logic [`PFC_DATA_W-1:0] cmd_data,
  output logic                        rsp_valid,
  output logic [`PFC_DATA_W-1:0]      rsp_data,
  output logic                        busy,
  output logic                        software_write_lock,
  output logic [`PFC_ADDR_W-1:0]      byte_addr_in,
  output logic [`PFC_DATA_W-1:0]      data_io_bus_o,
  output logic                        data_io_bus_oe,
  input  wire logic [`PFC_DATA_W-1:0] data_io_bus_i,
  output logic                        chip_sel_n,
  output logic                        out_en_n,
  output logic                        wr_strobe_n
);
  import pfc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SEQ, ST_SETUP, ST_EXEC, ST_WAIT, ST_READ, ST_CLEAR, ST_RESP
  } pfc_state_e;

  pfc_state_e               state_ff;
  pfc_op_e                  op_ff;
  logic [`PFC_ADDR_W-1:0]   addr_ff;
  logic [`PFC_DATA_W-1:0]   data_ff;
  logic [2:0]               seq_idx_ff;
  logic [`PFC_WAIT_W-1:0]   wait_ff;
  logic                     lock_ff;
  logic                     is_erase;

  pfc_cyc_if cyc ();

  pfc_bus_cycle u_cycle (
    .ref_clk        (ref_clk),
    .sys_rst        (sys_rst),
    .cyc            (cyc),
    .byte_addr_in   (byte_addr_in),
    .data_io_bus_o  (data_io_bus_o),
    .data_io_bus_oe (data_io_bus_oe),
    .data_io_bus_i  (data_io_bus_i),
    .chip_sel_n     (chip_sel_n),
    .out_en_n       (out_en_n),
    .wr_strobe_n    (wr_strobe_n)
  );

  // ---------------------------------------------------------------
  // Protection sequence addresses.
  // ---------------------------------------------------------------
  function automatic logic [`PFC_ADDR_W-1:0] seq_addr(input logic lock, input logic [2:0] idx);
    logic [`PFC_ADDR_W-1:0] a;
    unique case (idx)
      3'h0: a = `PFC_SEQ_A0;
      3'h1: a = `PFC_SEQ_A1;
      3'h2: a = `PFC_SEQ_A2;
      3'h3: a = `PFC_SEQ_A3;
      3'h4: a = `PFC_SEQ_A4;
      3'h5: a = `PFC_SEQ_A5;
      default: a = lock ? `PFC_SEQ_LOCK_A6 : `PFC_SEQ_UNLOCK_A6;
    endcase
    return a;
  endfunction

  assign is_erase  = (op_ff == PFC_OP_ERASE);
  assign cmd_ready = (state_ff == ST_IDLE);
  assign busy      = (state_ff != ST_IDLE);
  assign rsp_valid = (state_ff == ST_RESP);
  assign software_write_lock = lock_ff;

  // ---------------------------------------------------------------
  // Cycle request decode.
  // ---------------------------------------------------------------
  always_comb begin
    cyc.req   = 1'b0;
    cyc.wr    = 1'b0;
    cyc.addr  = `PFC_ANY_ADDR;
    cyc.wdata = `PFC_CMD_RESET;
    unique case (state_ff)
      ST_IDLE, ST_WAIT, ST_RESP: begin
        cyc.req = 1'b0;
      end
      ST_SEQ: begin
        cyc.req  = 1'b1;
        cyc.addr = seq_addr(op_ff == PFC_OP_LOCK, seq_idx_ff);
      end
      ST_SETUP: begin
        cyc.req = 1'b1;
        cyc.wr  = 1'b1;
        if (op_ff == PFC_OP_PROGRAM) begin
          cyc.wdata = `PFC_CMD_PROG_SETUP;
        end else if (is_erase) begin
          cyc.wdata = `PFC_CMD_ERASE_SETUP;
        end else begin
          cyc.wdata = `PFC_CMD_READ_ID;
        end
      end
      ST_EXEC: begin
        cyc.req = 1'b1;
        cyc.wr  = 1'b1;
        if (is_erase) begin
          cyc.addr  = {addr_ff[`PFC_ADDR_W-1:`PFC_SECTOR_LSB],
                       {`PFC_SECTOR_LSB{1'b0}}};
          cyc.wdata = `PFC_CMD_ERASE_EXEC;
        end else begin
          cyc.addr  = addr_ff;
          cyc.wdata = data_ff;
        end
      end
      ST_READ: begin
        cyc.req  = 1'b1;
        cyc.addr = (op_ff == PFC_OP_READ_ID) ?
                   {{(`PFC_ADDR_W-1){1'b0}}, addr_ff[0]} : addr_ff;
      end
      ST_CLEAR: begin
        cyc.req   = 1'b1;
        cyc.wr    = 1'b1;
        cyc.wdata = `PFC_CMD_RESET;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Operation sequencing.
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff   <= ST_IDLE;
      op_ff      <= PFC_OP_READ;
      addr_ff    <= '0;
      data_ff    <= '0;
      seq_idx_ff <= '0;
    end else begin
      unique case (state_ff)
        ST_IDLE: if (cmd_valid) begin
          op_ff      <= cmd_op;
          addr_ff    <= cmd_addr;
          data_ff    <= cmd_data;
          seq_idx_ff <= '0;
          unique case (cmd_op)
            PFC_OP_READ:                  state_ff <= ST_READ;
            PFC_OP_RESET:                 state_ff <= ST_CLEAR;
            PFC_OP_READ_ID:               state_ff <= ST_SETUP;
            PFC_OP_PROGRAM, PFC_OP_ERASE: state_ff <= ST_SEQ;
            PFC_OP_LOCK, PFC_OP_UNLOCK:   state_ff <= ST_SEQ;
          endcase
        end
        ST_SEQ: if (cyc.done) begin
          if (seq_idx_ff == `PFC_SEQ_LAST) begin
            state_ff <= (op_ff == PFC_OP_PROGRAM || is_erase) ? ST_SETUP : ST_RESP;
          end else begin
            seq_idx_ff <= seq_idx_ff + 1'b1;
          end
        end
        ST_SETUP: if (cyc.done) begin
          state_ff <= (op_ff == PFC_OP_READ_ID) ? ST_READ : ST_EXEC;
        end
        ST_EXEC: if (cyc.done) begin
          state_ff <= ST_WAIT;
        end
        ST_WAIT: if (wait_ff == '0) begin
          state_ff <= ST_RESP;
        end
        ST_READ: if (cyc.done) begin
          state_ff <= (op_ff == PFC_OP_READ_ID) ? ST_CLEAR : ST_RESP;
        end
        ST_CLEAR: if (cyc.done) begin
          state_ff <= ST_RESP;
        end
        ST_RESP: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Program and erase completion timer.
  // ---------------------------------------------------------------
  // The full worst-case time is waited out instead of polling the status bits,
  // so the host never reads the array while an operation is still running.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_ff <= '0;
    end else if (state_ff == ST_EXEC && cyc.done) begin
      wait_ff <= is_erase ? ERASE_WAIT_CYC - 1'b1 : PROG_WAIT_CYC - 1'b1;
    end else if (state_ff == ST_WAIT && wait_ff != '0) begin
      wait_ff <= wait_ff - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Response data and lock tracking.
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_data <= '0;
    end else if (state_ff == ST_READ && cyc.done) begin
      rsp_data <= cyc.rdata;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_ff <= 1'b1;
    end else if (state_ff == ST_SEQ && cyc.done && seq_idx_ff == `PFC_SEQ_LAST) begin
      lock_ff <= (op_ff == PFC_OP_LOCK);
    end
  end
endmodule
`default_nettype wire

// [core/pfc_consts.svh]
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH

`define PFC_ADDR_W        19
`define PFC_DATA_W        8
`define PFC_CLK_MHZ       125
`define PFC_SYNC_CYC      2

// Pin timing, each figure in its own unit and its cycle count derived from it.
`define PFC_T_SETUP_NS    20
`define PFC_T_STROBE_NS   250
`define PFC_T_HOLD_NS     20
`define PFC_T_PROG_US     35
`define PFC_T_ERASE_MS    4
`define PFC_SETUP_CYC     ((`PFC_T_SETUP_NS * `PFC_CLK_MHZ + 999) / 1000)
`define PFC_STROBE_CYC    ((`PFC_T_STROBE_NS * `PFC_CLK_MHZ + 999) / 1000 + `PFC_SYNC_CYC)
`define PFC_HOLD_CYC      ((`PFC_T_HOLD_NS * `PFC_CLK_MHZ + 999) / 1000)
`define PFC_PROG_CYC      (`PFC_T_PROG_US * `PFC_CLK_MHZ)
`define PFC_ERASE_CYC     (`PFC_T_ERASE_MS * 1000 * `PFC_CLK_MHZ)
`define PFC_PHASE_W       8
`define PFC_WAIT_W        20

// Command bytes.
`define PFC_CMD_ERASE_SETUP 8'h20
`define PFC_CMD_ERASE_EXEC  8'hd0
`define PFC_CMD_PROG_SETUP  8'h10
`define PFC_CMD_RESET       8'hff
`define PFC_CMD_READ_ID     8'h90

`define PFC_SECTOR_LSB    8
`define PFC_ANY_ADDR      19'h00000
`define PFC_SEQ_LAST      3'h6

// Seven-read protection sequences.
`define PFC_SEQ_A0        19'h01823
`define PFC_SEQ_A1        19'h01820
`define PFC_SEQ_A2        19'h01822
`define PFC_SEQ_A3        19'h00418
`define PFC_SEQ_A4        19'h0041b
`define PFC_SEQ_A5        19'h00419
`define PFC_SEQ_UNLOCK_A6 19'h0041a
`define PFC_SEQ_LOCK_A6   19'h0040a

`endif

// [core/pfc_pkg.sv]
`default_nettype none
package pfc_pkg;
  typedef enum logic [2:0] {
    PFC_OP_READ,
    PFC_OP_PROGRAM,
    PFC_OP_ERASE,
    PFC_OP_RESET,
    PFC_OP_READ_ID,
    PFC_OP_LOCK,
    PFC_OP_UNLOCK
  } pfc_op_e;
endpackage
`default_nettype wire

// [core/pfc_cyc_if.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pfc_consts.svh"
interface pfc_cyc_if;
  logic                    req;
  logic                    wr;
  logic [`PFC_ADDR_W-1:0]  addr;
  logic [`PFC_DATA_W-1:0]  wdata;
  logic                    done;
  logic [`PFC_DATA_W-1:0]  rdata;
  modport seq (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// [core/pfc_bus_cycle.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pfc_consts.svh"
module pfc_bus_cycle (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  pfc_cyc_if.eng                      cyc,
  output logic [`PFC_ADDR_W-1:0]      byte_addr_in,
  output logic [`PFC_DATA_W-1:0]      data_io_bus_o,
  output logic                        data_io_bus_oe,
  input  wire logic [`PFC_DATA_W-1:0] data_io_bus_i,
  output logic                        chip_sel_n,
  output logic                        out_en_n,
  output logic                        wr_strobe_n
);
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} pfc_eng_e;

  pfc_eng_e                 state_ff;
  logic [`PFC_PHASE_W-1:0]  cnt_ff;
  logic                     wr_ff;
  logic [`PFC_DATA_W-1:0]   sync1_ff;
  logic [`PFC_DATA_W-1:0]   sync2_ff;

  // ---------------------------------------------------------------
  // Read data synchroniser.
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= data_io_bus_i;
      sync2_ff <= sync1_ff;
    end
  end

  // ---------------------------------------------------------------
  // Phase sequencing.
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= E_IDLE;
      cnt_ff   <= '0;
      wr_ff    <= 1'b0;
    end else begin
      unique case (state_ff)
        // The sequencer still shows the finished request while done is high, so a
        // new cycle is only taken once done has dropped.
        E_IDLE: if (cyc.req && !cyc.done) begin
          state_ff <= E_SETUP;
          wr_ff    <= cyc.wr;
          cnt_ff   <= `PFC_PHASE_W'(`PFC_SETUP_CYC - 1);
        end
        E_SETUP: if (cnt_ff == '0) begin
          state_ff <= E_STROBE;
          cnt_ff   <= `PFC_PHASE_W'(`PFC_STROBE_CYC - 1);
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
        E_STROBE: if (cnt_ff == '0) begin
          state_ff <= E_HOLD;
          cnt_ff   <= `PFC_PHASE_W'(`PFC_HOLD_CYC - 1);
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
        E_HOLD: if (cnt_ff == '0) begin
          state_ff <= E_IDLE;
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drive.
  // ---------------------------------------------------------------
  // Address and data are set up before the strobes fall and held after they rise,
  // so the device's falling-edge address and rising-edge data latches see stable values.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_addr_in   <= '0;
      data_io_bus_o  <= '0;
      data_io_bus_oe <= 1'b0;
      chip_sel_n     <= 1'b1;
      out_en_n       <= 1'b1;
      wr_strobe_n    <= 1'b1;
    end else begin
      if (state_ff == E_IDLE && cyc.req && !cyc.done) begin
        byte_addr_in   <= cyc.addr;
        data_io_bus_o  <= cyc.wdata;
        data_io_bus_oe <= cyc.wr;
      end else if (state_ff == E_HOLD && cnt_ff == '0) begin
        data_io_bus_oe <= 1'b0;
      end
      if (state_ff == E_SETUP && cnt_ff == '0) begin
        chip_sel_n  <= 1'b0;
        wr_strobe_n <= !wr_ff;
        out_en_n    <= wr_ff;
      end else if (state_ff == E_STROBE && cnt_ff == '0) begin
        chip_sel_n  <= 1'b1;
        wr_strobe_n <= 1'b1;
        out_en_n    <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Completion and read capture.
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cyc.done  <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      cyc.done <= (state_ff == E_HOLD) && (cnt_ff == '0);
      if (state_ff == E_STROBE && cnt_ff == '0 && !wr_ff) begin
        cyc.rdata <= sync2_ff;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/pfc_host_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module pfc_host_chk (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        cmd_ready,
  input wire logic        rsp_valid,
  input wire logic        busy,
  input wire logic [18:0] byte_addr_in,
  input wire logic [7:0]  data_io_bus_o,
  input wire logic        data_io_bus_oe,
  input wire logic        chip_sel_n,
  input wire logic        out_en_n,
  input wire logic        wr_strobe_n
);
  // ----
  // Pin protocol of the flash port.
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_no_both: assert property (out_en_n || wr_strobe_n)
    else $error("read and write strobes low together");
  chk_no_fight: assert property (!out_en_n |-> !data_io_bus_oe)
    else $error("host drives bus during read");
  chk_read_start: assert property ($fell(out_en_n) |-> $fell(chip_sel_n) && wr_strobe_n)
    else $error("read strobes not lowered together");
  chk_write_start: assert property ($fell(wr_strobe_n) |->
    $fell(chip_sel_n) && out_en_n && data_io_bus_oe)
    else $error("write strobe without select or data");
  chk_addr_setup: assert property ($fell(chip_sel_n) |-> $past(byte_addr_in, 3) == byte_addr_in)
    else $error("address not set up before select");
  chk_addr_held: assert property (!chip_sel_n && $past(!chip_sel_n) |-> $stable(byte_addr_in))
    else $error("address moved while selected");
  chk_addr_hold: assert property ($rose(chip_sel_n) |=> $stable(byte_addr_in)[*2])
    else $error("address hold too short");
  chk_data_held: assert property (!wr_strobe_n && $past(!wr_strobe_n) |-> $stable(data_io_bus_o))
    else $error("write data moved under strobe");
  chk_data_hold: assert property ($rose(wr_strobe_n) |=> $stable(data_io_bus_o) && data_io_bus_oe)
    else $error("write data hold too short");
  chk_data_setup: assert property ($rose(data_io_bus_oe) |-> chip_sel_n[*3])
    else $error("write data not set up before select");
  chk_strobe_width: assert property ($fell(chip_sel_n) |-> !chip_sel_n[*8])
    else $error("select pulse too short");
  chk_idle_pins: assert property (cmd_ready |-> chip_sel_n && out_en_n && wr_strobe_n
    && !data_io_bus_oe)
    else $error("pins active while idle");
  chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid && cmd_ready)
    else $error("response not a single pulse");
  chk_busy_pins: assert property (!chip_sel_n |-> busy)
    else $error("flash selected while not busy");
  cov_write: cover property ($fell(wr_strobe_n));
  cov_read: cover property ($fell(out_en_n));
  cov_rsp: cover property (rsp_valid);
endmodule
bind pfc_host pfc_host_chk u_chk (.ref_clk, .sys_rst, .cmd_ready, .rsp_valid, .busy, .byte_addr_in,
  .data_io_bus_o, .data_io_bus_oe, .chip_sel_n, .out_en_n, .wr_strobe_n);
`default_nettype wire

// [tb/pfc_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pfc_consts.svh"
module pfc_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h5e, // Arbitrary value.
  parameter logic [7:0] PART_ID  = 8'h2b, // Arbitrary value.
  parameter realtime    PROG_NS  = 150.0,
  parameter realtime    ERASE_NS = 390.0
) (
  input  wire logic        chip_sel_n,
  input  wire logic        out_en_n,
  input  wire logic        wr_strobe_n,
  input  wire logic [18:0] byte_addr_in,
  input  wire logic [7:0]  data_in,
  output logic [7:0]       data_out,
  output logic             data_oe,
  output logic             lock_ff,
  output int               early_cnt
);
  // ----
  // Behavioural flash array and command decoder.
  // ----
  localparam logic [18:0] SEQ [6] = '{`PFC_SEQ_A0, `PFC_SEQ_A1, `PFC_SEQ_A2, `PFC_SEQ_A3,
    `PFC_SEQ_A4, `PFC_SEQ_A5};
  logic [7:0]  mem [int];
  logic [1:0]  state_ff;
  int          seq_ff;
  logic [18:0] wa_ff;
  realtime     busy_until;
  wire wr_act = !chip_sel_n && !wr_strobe_n && out_en_n;
  wire rd_act = !chip_sel_n && !out_en_n && wr_strobe_n;
  assign data_oe = rd_act;
  initial begin
    lock_ff = 1'b1;
    state_ff = 2'd0;
    seq_ff = 0;
    early_cnt = 0;
    busy_until = 0.0;
  end
  // Any select before the internal timer ends is an early access.
  always @(negedge chip_sel_n) if ($realtime < busy_until) early_cnt++;
  always @(posedge wr_act) wa_ff = byte_addr_in;
  always @(negedge wr_act) begin
    case (state_ff)
      2'd1: begin
        if (data_in == 8'hd0) begin
          for (int i = 0; i < 256; i++) mem.delete(int'({wa_ff[18:8], 8'(i)}));
          busy_until = $realtime + ERASE_NS;
        end
        state_ff = 2'd0;
      end
      2'd2: begin
        if (data_in != 8'hff) begin
          mem[int'(wa_ff)] = data_in;
          busy_until = $realtime + PROG_NS;
        end
        state_ff = 2'd0;
      end
      default: state_ff = (data_in == 8'h20 && !lock_ff) ? 2'd1 :
        (data_in == 8'h10 && !lock_ff) ? 2'd2 : (data_in == 8'h90) ? 2'd3 : 2'd0;
    endcase
    seq_ff = 0;
  end
  always @(negedge rd_act) begin
    if (seq_ff == 6 && (byte_addr_in == `PFC_SEQ_UNLOCK_A6 || byte_addr_in == `PFC_SEQ_LOCK_A6)) begin
      lock_ff = (byte_addr_in == `PFC_SEQ_LOCK_A6);
      seq_ff = 0;
    end else if (seq_ff < 6 && byte_addr_in == SEQ[seq_ff]) seq_ff++;
    else seq_ff = (byte_addr_in == SEQ[0]) ? 1 : 0;
  end
  always @(byte_addr_in or rd_act or state_ff) begin
    if (state_ff == 2'd3 && byte_addr_in[18:1] == 18'h0)
      data_out = byte_addr_in[0] ? PART_ID : MAKER_ID;
    else data_out = mem.exists(int'(byte_addr_in)) ? mem[int'(byte_addr_in)] : 8'hff;
  end
endmodule
`default_nettype wire

// [tb/pfc_host_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module pfc_host_bench;
  import pfc_pkg::*;
  // ----
  // Clock, reset, pins and the flash model.
  // ----
  logic              ref_clk;
  logic              sys_rst;
  logic              cmd_valid;
  logic              cmd_ready;
  pfc_op_e           cmd_op;
  logic [18:0]       cmd_addr;
  logic [7:0]        cmd_data;
  logic              rsp_valid;
  logic [7:0]        rsp_data;
  logic              busy;
  logic              software_write_lock;
  logic [18:0]       byte_addr_in;
  logic [7:0]        dq_o;
  logic              dq_oe;
  logic              chip_sel_n;
  logic              out_en_n;
  logic              wr_strobe_n;
  logic [7:0]        fl_o;
  logic              fl_oe;
  logic              fl_lock;
  int                early;
  logic [7:0]        flt_ff;
  wire  [7:0]        bus = dq_oe ? dq_o : fl_oe ? fl_o : flt_ff;
  int                miscompares;
  int                compares;
  logic [7:0]        r;
  pfc_host #(.PROG_WAIT_CYC(20'd20), .ERASE_WAIT_CYC(20'd50)) dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .busy(busy), .software_write_lock(software_write_lock), .byte_addr_in(byte_addr_in),
    .data_io_bus_o(dq_o), .data_io_bus_oe(dq_oe), .data_io_bus_i(bus),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n));
  pfc_flash_model flash (.chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .wr_strobe_n(wr_strobe_n), .byte_addr_in(byte_addr_in), .data_in(bus),
    .data_out(fl_o), .data_oe(fl_oe), .lock_ff(fl_lock), .early_cnt(early));
  // A released bus shows a pattern that flips every cycle.
  always @(posedge ref_clk) flt_ff <= ~flt_ff;
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ----
  // Shared tasks.
  // ----
  task automatic op(input pfc_op_e o, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (rsp_valid !== 1'b1 && n < 3000);
    if (n >= 3000) miscompares++;
    r = rsp_data;
  endtask
  task automatic rd_chk(input logic [18:0] a, input logic [7:0] e);
    op(PFC_OP_READ, a, 8'h00);
    `CHECK_EQ(r, e)
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // Scenarios.
  // ----
  task automatic t_reset();
    `CHECK_EQ(software_write_lock, 1'b1)
    `CHECK_EQ(fl_lock, 1'b1)
    `CHECK_EQ(chip_sel_n, 1'b1)
    rd_chk(19'h00055, 8'hff);
    $display("test reset done");
  endtask
  task automatic t_program();
    op(PFC_OP_PROGRAM, 19'h7ffff, 8'h3c);
    `CHECK_EQ(fl_lock, 1'b0)
    op(PFC_OP_PROGRAM, 19'h00001, 8'ha5);
    rd_chk(19'h7ffff, 8'h3c);
    rd_chk(19'h00001, 8'ha5);
    `CHECK_EQ(early, 0)
    $display("test program done");
  endtask
  task automatic t_erase();
    op(PFC_OP_PROGRAM, 19'h12300, 8'h11);
    op(PFC_OP_PROGRAM, 19'h123ff, 8'h22);
    op(PFC_OP_PROGRAM, 19'h12400, 8'h33);
    op(PFC_OP_ERASE, 19'h123aa, 8'h00);
    rd_chk(19'h12300, 8'hff);
    rd_chk(19'h123ff, 8'hff);
    rd_chk(19'h12400, 8'h33);
    `CHECK_EQ(early, 0)
    $display("test erase done");
  endtask
  task automatic t_lock_id();
    op(PFC_OP_LOCK, 19'h00000, 8'h00);
    `CHECK_EQ(fl_lock, 1'b1)
    `CHECK_EQ(software_write_lock, 1'b1)
    op(PFC_OP_READ_ID, 19'h00000, 8'h00);
    `CHECK_EQ(r, 8'h5e)
    op(PFC_OP_READ_ID, 19'h00001, 8'h00);
    `CHECK_EQ(r, 8'h2b)
    rd_chk(19'h12400, 8'h33);
    op(PFC_OP_RESET, 19'h00000, 8'h00);
    rd_chk(19'h7ffff, 8'h3c);
    op(PFC_OP_UNLOCK, 19'h00000, 8'h00);
    `CHECK_EQ(fl_lock, 1'b0)
    `CHECK_EQ(software_write_lock, 1'b0)
    $display("test lock and id done");
  endtask
  initial begin
    miscompares = 0;
    compares = 0;
    flt_ff = 8'h5a;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = PFC_OP_READ;
    cmd_addr = 19'h00000;
    cmd_data = 8'h00;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1 t_reset();
    t_program();
    t_erase();
    t_lock_id();
    results();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
